// >>> design/mst_map.vh
`ifndef MST_MAP_VH
`define MST_MAP_VH
// Register byte addresses
`define MST_ADDR_CTRL       8'h00
`define MST_ADDR_TON        8'h04
`define MST_ADDR_TOFF       8'h08
`define MST_ADDR_STATUS     8'h0C
`define MST_ADDR_TRACK      8'h10
// Control register fields
`define MST_CTRL_INHIBIT    0
// Status register fields
`define MST_ST_MODE_LO      0
`define MST_ST_SUP_EN       2
`define MST_ST_TEMP         3
`define MST_ST_UV           4
`define MST_ST_RUN          5
`define MST_ST_STAGE2       6
`define MST_ST_GATE         7
`define MST_ST_LOCK         8
`define MST_ST_EN           9
`define MST_ST_FIRST        10
`define MST_ST_RAMP_LO      12
// Mode codes from the three-state mode pin
`define MST_MODE_STATIC     2'h0
`define MST_MODE_SWOFF      2'h1
`define MST_MODE_PLAIN      2'h2
// Ramp sequencer states
`define MST_R_DIS           3'h0
`define MST_R_PRE           3'h1
`define MST_R_ON            3'h2
`define MST_R_POST          3'h3
// Timing, in milliseconds and in mains half-wave ticks
`define MST_HALFWAVE_MS     10
`define MST_TON_MS          40
`define MST_TOFF_MS         640
`define MST_TON_TICKS       8'h04
`define MST_TOFF_TICKS      8'h40
`define MST_TRACK_DIV       2048
// Bus responses
`define MST_RESP_OKAY       2'h0
`define MST_RESP_SLVERR     2'h2
`endif

// >>> design/mst_sync3.v
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; output follows once stages two and three agree
module mst_sync3 #(
   parameter W = 1
) (
   input  wire         clk,
   input  wire         nrst,
   input  wire [W-1:0] din,
   output reg  [W-1:0] dout
);
   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;
   reg [W-1:0] s3_r;
   integer     i;

   // Shift chain and agreement filter
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s1_r <= {W{1'b0}};
         s2_r <= {W{1'b0}};
         s3_r <= {W{1'b0}};
         dout <= {W{1'b0}};
      end
      else
      begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
         for (i = 0; i < W; i = i + 1)
            if (s2_r[i] == s3_r[i])
               dout[i] <= s3_r[i];
      end
   end
endmodule
`default_nettype wire

// >>> design/mst_timer_ctrl.v
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "mst_map.vh"
// Overview of operation
// - Falling of sync pin below its threshold marks a zero-crossing event.
// - Zero-crossing events form the slow tick for filter and lockout counters.
// - Without a valid supply, all latches, divider and sequencer held reset, output off.
// - Supply enable follows the 16 V flag; loss at 11 V resets again.
// - In phase modes a 12.5 V dip drops the output until next half-wave.
// - One operating cycle starts after power-up release without a trigger; a new trigger restarts it, and in plain mode enable low ends it.
// - Over-temperature latches output off until the supply is cycled.
// - Zero crossing selects high ramp current; at 0.45 V output on, nominal current.
// - At end angle output off, high current; at 5.5 V stop and discharge.
// - Mode pin: reference static switching, supply switch-off mode, ground plain mode.
// - Static mode: ramp idle, output follows timer, changes only at zero crossings.
// - Switch-off mode: maximum angle, set angle after 3/4, off at expiry.
// - Plain mode: new window trigger restarts; enable loss drops load at once, without waiting for a half-wave.
// - Plain mode: enable alone turns output on at the set angle.
// - Trigger condition is enable state AND window state.
// - Enable turns on near 2.5 V; releases at 2 V when off or stage two, else 0.5 V.
// - Window trigger is active only when sensor lies outside the window.
// - A trigger counts only after persisting 40 ms.
// - Triggers are ignored for 640 ms after every load switch-off.
// - With one sync event per mains period, all tick-based delays double.
// - Tracking time is 2048 prescaled ticks, each 2048 oscillator periods from a divide-by-2048 stage.
module mst_timer_ctrl #(
   parameter TRACK_DIV = `MST_TRACK_DIV
) (
   input  wire        clk,
   input  wire        nrst,
   input  wire        sync_below_lvl,
   input  wire        sup_on_lvl,
   input  wire        sup_hold_lvl,
   input  wire        sup_uv_ok_lvl,
   input  wire        over_temp_lvl,
   input  wire        mode_ref_lvl,
   input  wire        mode_sup_lvl,
   input  wire        en_above_on,
   input  wire        en_above_2v,
   input  wire        en_above_0v5,
   input  wire        win_outside,
   input  wire        ramp_at_low,
   input  wire        ramp_at_ctrl,
   input  wire        ramp_at_high,
   input  wire        osc_in,
   output reg         gate_on,
   output reg         ramp_hi_cur,
   output reg         ramp_charge,
   output reg         ramp_discharge,
   output reg         en_rel_hi_sel,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready
);
   localparam TW = 12;

   wire [15:0] pin_s;
   reg         sync_d_r;
   reg         osc_d_r;
   reg         sup_en_r;
   wire        run_ok;
   wire        zc;
   wire        osc_rise;
   wire [1:0]  mode;
   wire        rpc;
   reg         inhibit_r;
   reg  [7:0]  ton_r;
   reg  [7:0]  toff_r;
   reg         temp_r;
   reg         uv_r;
   reg         first_r;
   reg         en_st_r;
   reg  [7:0]  filt_r;
   reg         qual_r;
   reg  [7:0]  lock_r;
   reg  [10:0] pre_r;
   reg  [TW-1:0] trk_r;
   reg         run_r;
   reg         load_d_r;
   reg         static_out_r;
   reg  [2:0]  rst_r;
   reg  [2:0]  rst_nxt;
   wire        trig_cond;
   wire        qual_nxt;
   wire        new_trig;
   wire        stage2;
   wire        load_req;
   wire        gate_ok;
   wire        end_hit;
   wire        aw_take;
   wire        ar_take;
   reg  [31:0] rd_nxt;

   // Every comparator and pin flag crosses into the clock domain here
   mst_sync3 #(
      .W (16)
   ) u_sync (
      .clk  (clk),
      .nrst (nrst),
      .din  ({osc_in, ramp_at_high, ramp_at_ctrl, ramp_at_low, win_outside, en_above_0v5, en_above_2v,
              en_above_on, mode_sup_lvl, mode_ref_lvl, over_temp_lvl, sup_uv_ok_lvl, sup_hold_lvl,
              sup_on_lvl, sync_below_lvl, 1'b0}),
      .dout (pin_s)
   );

   assign zc       = pin_s[1] & ~sync_d_r;
   assign osc_rise = pin_s[15] & ~osc_d_r;
   assign mode     = pin_s[6] ? `MST_MODE_STATIC :
                     (pin_s[7] ? `MST_MODE_SWOFF : `MST_MODE_PLAIN);
   assign rpc      = (mode != `MST_MODE_STATIC);
   assign run_ok   = sup_en_r;

   // Supply enable: set at the clamp level, lost at the low level
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         sup_en_r <= 1'b0;
      else if (!pin_s[3])
         sup_en_r <= 1'b0;
      else if (pin_s[2])
         sup_en_r <= 1'b1;
   end

   // Edge history of the sync and oscillator levels
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sync_d_r <= 1'b0;
         osc_d_r  <= 1'b0;
      end
      else
      begin
         sync_d_r <= pin_s[1];
         osc_d_r  <= pin_s[15];
      end
   end

   // Enable comparator hysteresis with switched release level
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         en_st_r <= 1'b0;
      else if (!run_ok)
         en_st_r <= 1'b0;
      else if (pin_s[8])
         en_st_r <= 1'b1;
      else if (en_rel_hi_sel ? !pin_s[9] : !pin_s[10])
         en_st_r <= 1'b0;
   end

   assign trig_cond = en_st_r & pin_s[11];
   assign qual_nxt  = trig_cond & (filt_r >= ton_r);
   assign new_trig  = (qual_nxt & ~qual_r & (lock_r == 8'h00)) | first_r;

   // Noise filter and lockout count zero-crossing ticks
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         filt_r <= 8'h00;
         qual_r <= 1'b0;
         lock_r <= 8'h00;
      end
      else if (!run_ok)
      begin
         filt_r <= 8'h00;
         qual_r <= 1'b0;
         lock_r <= 8'h00;
      end
      else
      begin
         qual_r <= qual_nxt;
         if (!trig_cond)
            filt_r <= 8'h00;
         else if (zc && filt_r != 8'hFF)
            filt_r <= filt_r + 8'h01;
         if (load_d_r && !load_req)
            lock_r <= toff_r;
         else if (zc && lock_r != 8'h00)
            lock_r <= lock_r - 8'h01;
      end
   end

   // Tracking timer behind the divide-by-2048 prescaler
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pre_r   <= 11'h000;
         trk_r   <= {TW{1'b0}};
         run_r   <= 1'b0;
         first_r <= 1'b1;
      end
      else if (!run_ok)
      begin
         pre_r   <= 11'h000;
         trk_r   <= {TW{1'b0}};
         run_r   <= 1'b0;
         first_r <= 1'b1;
      end
      else if (new_trig)
      begin
         first_r <= 1'b0;
         pre_r   <= 11'h000;
         trk_r   <= {TW{1'b0}};
         run_r   <= 1'b1;
      end
      else if (mode == `MST_MODE_PLAIN && !en_st_r)
         run_r <= 1'b0;
      else if (run_r && osc_rise)
      begin
         if (pre_r == 11'h7FF)
         begin
            pre_r <= 11'h000;
            trk_r <= trk_r + {{(TW-1){1'b0}}, 1'b1};
            if (trk_r == TRACK_DIV[TW-1:0] - {{(TW-1){1'b0}}, 1'b1})
               run_r <= 1'b0;
         end
         else
            pre_r <= pre_r + 11'h001;
      end
   end

   assign stage2   = (run_r && trk_r >= (TRACK_DIV[TW-1:0] - (TRACK_DIV[TW-1:0] >> 2))) ||
                     (!run_r && mode == `MST_MODE_PLAIN);
   assign load_req = run_r | ((mode == `MST_MODE_PLAIN) & en_st_r);
   assign gate_ok  = run_ok & ~temp_r & ~uv_r & ~inhibit_r;
   assign end_hit  = stage2 ? pin_s[13] : pin_s[14];

   // Protection latches: over-temperature and undervoltage
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         temp_r   <= 1'b0;
         uv_r     <= 1'b0;
         load_d_r <= 1'b0;
      end
      else if (!run_ok)
      begin
         temp_r   <= 1'b0;
         uv_r     <= 1'b0;
         load_d_r <= 1'b0;
      end
      else
      begin
         load_d_r <= load_req;
         if (pin_s[5])
            temp_r <= 1'b1;
         if (rpc && !pin_s[4])
            uv_r <= 1'b1;
         else if (zc)
            uv_r <= 1'b0;
      end
   end

   // Ramp sequencer next state
   always @*
   begin
      rst_nxt = rst_r;
      case (rst_r)
         `MST_R_PRE:  if (pin_s[12]) rst_nxt = `MST_R_ON;
         `MST_R_ON:   if (end_hit) rst_nxt = `MST_R_POST;
         `MST_R_POST: if (pin_s[14]) rst_nxt = `MST_R_DIS;
         `MST_R_DIS:  rst_nxt = `MST_R_DIS;
         default:     rst_nxt = `MST_R_DIS;
      endcase
      if (zc)
         rst_nxt = `MST_R_PRE;
      if (!rpc)
         rst_nxt = `MST_R_DIS;
   end

   // Ramp state and static-mode output latch
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_r        <= `MST_R_DIS;
         static_out_r <= 1'b0;
      end
      else if (!run_ok)
      begin
         rst_r        <= `MST_R_DIS;
         static_out_r <= 1'b0;
      end
      else
      begin
         rst_r <= rst_nxt;
         if (zc)
            static_out_r <= run_r;
      end
   end

   // Output stage and ramp current controls
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         gate_on        <= 1'b0;
         ramp_hi_cur    <= 1'b0;
         ramp_charge    <= 1'b0;
         ramp_discharge <= 1'b1;
         en_rel_hi_sel  <= 1'b1;
      end
      else
      begin
         if (!rpc)
            gate_on <= gate_ok & static_out_r;
         else
            gate_on <= gate_ok & load_req & (rst_nxt == `MST_R_ON);
         ramp_hi_cur    <= run_ok && ((rst_nxt == `MST_R_PRE) || (rst_nxt == `MST_R_POST));
         ramp_charge    <= run_ok && rst_nxt != `MST_R_DIS;
         ramp_discharge <= !run_ok || rst_nxt == `MST_R_DIS;
         en_rel_hi_sel  <= !load_req || stage2;
      end
   end

   // Bus slave: write address and data taken together, one response pending
   assign aw_take       = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
   assign s_axi_awready = aw_take;
   assign s_axi_wready  = aw_take;
   assign ar_take       = s_axi_arvalid & ~s_axi_rvalid;
   assign s_axi_arready = ~s_axi_rvalid;

   // Register writes and write response
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         inhibit_r    <= 1'b0;
         ton_r        <= `MST_TON_TICKS;
         toff_r       <= `MST_TOFF_TICKS;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `MST_RESP_OKAY;
      end
      else
      begin
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (aw_take)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `MST_RESP_OKAY;
            case (s_axi_awaddr)
               `MST_ADDR_CTRL: if (s_axi_wstrb[0]) inhibit_r <= s_axi_wdata[`MST_CTRL_INHIBIT];
               `MST_ADDR_TON:  if (s_axi_wstrb[0]) ton_r <= s_axi_wdata[7:0];
               `MST_ADDR_TOFF: if (s_axi_wstrb[0]) toff_r <= s_axi_wdata[7:0];
               `MST_ADDR_STATUS, `MST_ADDR_TRACK: s_axi_bresp <= `MST_RESP_OKAY;
               default:        s_axi_bresp <= `MST_RESP_SLVERR;
            endcase
         end
      end
   end

   // Read data multiplexer
   always @*
   begin
      rd_nxt = 32'h0000_0000;
      case (s_axi_araddr)
         `MST_ADDR_CTRL:   rd_nxt[`MST_CTRL_INHIBIT] = inhibit_r;
         `MST_ADDR_TON:    rd_nxt[7:0] = ton_r;
         `MST_ADDR_TOFF:   rd_nxt[7:0] = toff_r;
         `MST_ADDR_STATUS:
         begin
            rd_nxt[1:0]              = mode;
            rd_nxt[`MST_ST_SUP_EN]   = sup_en_r;
            rd_nxt[`MST_ST_TEMP]     = temp_r;
            rd_nxt[`MST_ST_UV]       = uv_r;
            rd_nxt[`MST_ST_RUN]      = run_r;
            rd_nxt[`MST_ST_STAGE2]   = stage2;
            rd_nxt[`MST_ST_GATE]     = gate_on;
            rd_nxt[`MST_ST_LOCK]     = (lock_r != 8'h00);
            rd_nxt[`MST_ST_EN]       = en_st_r;
            rd_nxt[`MST_ST_FIRST]    = first_r;
            rd_nxt[14:12]            = rst_r;
         end
         `MST_ADDR_TRACK:  rd_nxt[TW-1:0] = trk_r;
         default:          rd_nxt = 32'h0000_0000;
      endcase
   end

   // Read response, one cycle after address taken
   always @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `MST_RESP_OKAY;
      end
      else if (ar_take)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_nxt;
         s_axi_rresp  <= (s_axi_araddr == `MST_ADDR_CTRL || s_axi_araddr == `MST_ADDR_TON ||
                          s_axi_araddr == `MST_ADDR_TOFF || s_axi_araddr == `MST_ADDR_STATUS ||
                          s_axi_araddr == `MST_ADDR_TRACK) ? `MST_RESP_OKAY : `MST_RESP_SLVERR;
      end
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end
endmodule
`default_nettype wire

// >>> verification/mst_timer_chk.sv
`timescale 1ns/1ps
`default_nettype none
module mst_timer_chk (
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        sup_hold_lvl,
   input wire logic        over_temp_lvl,
   input wire logic        mode_ref_lvl,
   input wire logic        gate_on,
   input wire logic        ramp_hi_cur,
   input wire logic        ramp_charge,
   input wire logic        ramp_discharge,
   input wire logic        en_rel_hi_sel,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // Write and read acceptance steps
   sequence wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
   endsequence
   sequence rd_take;
      s_axi_arvalid && s_axi_arready && !s_axi_rvalid;
   endsequence
   reset_vals_a: assert property (
      $rose(nrst) |-> !gate_on && ramp_discharge && en_rel_hi_sel) else $error("bad outputs after reset");
   wr_answer_a: assert property (wr_take |=> s_axi_bvalid) else $error("write not answered");
   wr_stands_a: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer moved");
   rd_answer_a: assert property (rd_take |=> s_axi_rvalid) else $error("read not answered");
   rd_stands_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)
      && $stable(s_axi_rresp)) else $error("read answer moved");
   rd_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid stuck");
   supply_loss_a: assert property (
      !sup_hold_lvl [*8] |-> !gate_on) else $error("gate on without supply");
   over_temp_a: assert property (
      over_temp_lvl [*8] |-> !gate_on) else $error("gate on while hot");
   static_ramp_a: assert property (
      mode_ref_lvl [*8] |-> ramp_discharge && !ramp_charge) else $error("ramp active in static mode");
   ramp_excl_a: assert property (
      ramp_charge |-> !ramp_discharge) else $error("charge and discharge together");
   gate_cur_a: assert property (
      gate_on |-> !ramp_hi_cur) else $error("high current while gate on");
endmodule
bind mst_timer_ctrl mst_timer_chk chk_u (.*);
`default_nettype wire

// >>> verification/mst_timer_far.sv
`timescale 1ns/1ps
`default_nettype none
// Mains sync, ramp capacitor and RC oscillator seen from the block
module mst_timer_far #(
   parameter int HALF = 200,
   parameter int CTRL = 30
) (
   input wire logic  clk,
   input wire logic  ramp_hi_cur,
   input wire logic  ramp_charge,
   input wire logic  ramp_discharge,
   output wire logic sync_below_lvl,
   output wire logic ramp_at_low,
   output wire logic ramp_at_ctrl,
   output wire logic ramp_at_high,
   output wire logic osc_in
);
   int ph = 0;
   int lvl = 0;
   int oc = 0;
   // Half-wave phase, oscillator phase and ramp level
   always @(posedge clk)
   begin
      ph <= (ph == HALF - 1) ? 0 : ph + 1;
      oc <= (oc == 5) ? 0 : oc + 1;
      if (ramp_discharge)
         lvl <= 0;
      else if (ramp_charge)
         lvl <= lvl + (ramp_hi_cur ? 4 : 1);
   end
   // Comparator levels: 4 is the low mark, 60 the top
   assign sync_below_lvl = ph < 20;
   assign osc_in = oc < 3;
   assign ramp_at_low = lvl >= 4;
   assign ramp_at_ctrl = lvl >= CTRL;
   assign ramp_at_high = lvl >= 60;
endmodule
`default_nettype wire

// >>> verification/mst_timer_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "mst_map.vh"
module mst_timer_ctrl_test;
   logic clk, nrst, sup_on_lvl, sup_hold_lvl, sup_uv_ok_lvl, over_temp_lvl, mode_ref_lvl, mode_sup_lvl;
   logic en_above_on, en_above_2v, en_above_0v5, win_outside, s_axi_awvalid, s_axi_wvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata;
   logic [3:0] s_axi_wstrb;
   wire logic sync_below_lvl, ramp_at_low, ramp_at_ctrl, ramp_at_high, osc_in, gate_on, ramp_hi_cur;
   wire logic ramp_charge, ramp_discharge, en_rel_hi_sel, s_axi_awready, s_axi_wready, s_axi_bvalid;
   wire logic s_axi_arready, s_axi_rvalid;
   wire logic [1:0] s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   logic [65:0] rq[$];
   logic [1:0] wq[$];
   int n_fail = 0;
   int comparisons = 0;
   int cyc = 0;
   logic [31:0] t;
   mst_timer_ctrl #(.TRACK_DIV(4)) dut_u (.*);
   mst_timer_far far_u (.*);
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic fail(input string m);
      n_fail++;
      $display("ERROR %0t %s", $time, m);
   endtask
   task automatic end_sim;
      $display("comparisons %0d, mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Bus master: write, then wait for the response
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      wq.push_back(r);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b0;
      do @(posedge clk); while (!(s_axi_awready && s_axi_wready));
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid <= 1'b0;
      // Late response acceptance makes the slave hold its answer
      repeat ($urandom_range(0, 2)) @(posedge clk);
      s_axi_bready <= 1'b1;
      do @(posedge clk); while (!s_axi_bvalid);
   endtask
   // Bus master: read; only bits under the mask are compared
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m, input logic [1:0] r);
      rq.push_back({m, d, r});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b0;
      do @(posedge clk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      repeat ($urandom_range(0, 2)) @(posedge clk);
      s_axi_rready <= 1'b1;
      do @(posedge clk); while (!s_axi_rvalid);
   endtask
   task automatic cmp_pin(input logic g, input logic e);
      comparisons++;
      if (g !== e)
         fail("output pin level wrong");
   endtask
   task automatic wait_gate(input logic v);
      int k;
      k = 0;
      while (gate_on !== v && k < 3000)
      begin
         @(posedge clk);
         k++;
      end
   endtask
   // Response monitor: oldest note against each answer
   always @(posedge clk)
   begin
      logic [65:0] e;
      if (s_axi_bvalid && s_axi_bready)
      begin
         comparisons++;
         if (wq.size() == 0 || s_axi_bresp !== wq.pop_front())
            fail("write response wrong");
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
         comparisons++;
         e = (rq.size() != 0) ? rq.pop_front() : 66'h0;
         if ((s_axi_rdata & e[65:34]) !== e[33:2] || s_axi_rresp !== e[1:0])
            fail("read data or response wrong");
      end
   end
   // Hang guard
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 70000)
      begin
         fail("timeout");
         end_sim;
      end
   end
   initial
   begin
      void'($urandom(32'h6B53));
      {nrst, sup_on_lvl, sup_hold_lvl, sup_uv_ok_lvl, over_temp_lvl, mode_ref_lvl} = 6'h00;
      {mode_sup_lvl, en_above_on, en_above_2v, en_above_0v5, win_outside} = 5'h00;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      s_axi_wstrb = 4'hF;
      s_axi_bready = 1'b1;
      s_axi_rready = 1'b1;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      // Reset values, unmapped and read-only places
      rd(`MST_ADDR_CTRL, 32'h0, 32'hFF, `MST_RESP_OKAY);
      rd(`MST_ADDR_TON, 32'h4, 32'hFF, `MST_RESP_OKAY);
      rd(`MST_ADDR_TOFF, 32'h40, 32'hFF, `MST_RESP_OKAY);
      rd(8'h14, 32'h0, 32'hFFFFFFFF, `MST_RESP_SLVERR);
      wr(8'h14, 32'h1, `MST_RESP_SLVERR);
      wr(`MST_ADDR_STATUS, 32'hFF, `MST_RESP_OKAY);
      rd(`MST_ADDR_STATUS, 32'h0, 32'h4, `MST_RESP_OKAY);
      t = $urandom_range(1, 7);
      wr(`MST_ADDR_TON, t, `MST_RESP_OKAY);
      rd(`MST_ADDR_TON, t, 32'hFF, `MST_RESP_OKAY);
      wr(`MST_ADDR_TOFF, 32'h2, `MST_RESP_OKAY);
      // Mode pin decoding, every code
      for (int i = 0; i < 3; i++)
      begin
         mode_ref_lvl <= (i == 0);
         mode_sup_lvl <= (i == 1);
         repeat (12) @(posedge clk);
         rd(`MST_ADDR_STATUS, i, 32'h3, `MST_RESP_OKAY);
      end
      // Supply up in switch-off mode, no trigger: one cycle must run
      mode_sup_lvl <= 1'b1;
      {sup_on_lvl, sup_hold_lvl, sup_uv_ok_lvl} <= 3'h7;
      repeat (20) @(posedge clk);
      rd(`MST_ADDR_STATUS, 32'h24, 32'h24, `MST_RESP_OKAY);
      wait_gate(1'b1);
      cmp_pin(gate_on, 1'b1);
      // Supply dip drops the gate but not the timer
      sup_uv_ok_lvl <= 1'b0;
      repeat (20) @(posedge clk);
      cmp_pin(gate_on, 1'b0);
      rd(`MST_ADDR_STATUS, 32'h30, 32'h30, `MST_RESP_OKAY);
      sup_uv_ok_lvl <= 1'b1;
      wait_gate(1'b1);
      cmp_pin(gate_on, 1'b1);
      // Stage two after 3 of 4 track ticks, off after 4
      repeat (39000) @(posedge clk);
      rd(`MST_ADDR_STATUS, 32'h60, 32'h60, `MST_RESP_OKAY);
      repeat (11000) @(posedge clk);
      rd(`MST_ADDR_STATUS, 32'h0, 32'h20, `MST_RESP_OKAY);
      t = 0;
      repeat (600) @(posedge clk) t[0] = t[0] | gate_on;
      cmp_pin(t[0], 1'b0);
      // Over-temperature latch holds until the supply is cycled
      over_temp_lvl <= 1'b1;
      repeat (20) @(posedge clk);
      over_temp_lvl <= 1'b0;
      repeat (20) @(posedge clk);
      rd(`MST_ADDR_STATUS, 32'h8, 32'h8, `MST_RESP_OKAY);
      {sup_on_lvl, sup_hold_lvl} <= 2'h0;
      repeat (20) @(posedge clk);
      rd(`MST_ADDR_STATUS, 32'h0, 32'h2C, `MST_RESP_OKAY);
      sup_on_lvl <= 1'b1;
      sup_hold_lvl <= 1'b1;
      repeat (20) @(posedge clk);
      rd(`MST_ADDR_STATUS, 32'h24, 32'h2C, `MST_RESP_OKAY);
      // Plain mode: enable alone lights the load at the set angle, high release level
      mode_sup_lvl <= 1'b0;
      {en_above_on, en_above_2v, en_above_0v5} <= 3'h7;
      wait_gate(1'b1);
      cmp_pin(gate_on, 1'b1);
      cmp_pin(en_rel_hi_sel, 1'b1);
      // Enable loss drops the load; then let the lockout run out
      {en_above_on, en_above_2v, en_above_0v5} <= 3'h0;
      wait_gate(1'b0);
      cmp_pin(gate_on, 1'b0);
      repeat (700) @(posedge clk);
      // Enable and window together start the timer once the filter has run
      {en_above_on, en_above_2v, en_above_0v5, win_outside} <= 4'hF;
      repeat (2400) @(posedge clk);
      rd(`MST_ADDR_STATUS, 32'h20, 32'h60, `MST_RESP_OKAY);
      cmp_pin(en_rel_hi_sel, 1'b0);
      end_sim;
   end
endmodule
`default_nettype wire
